// *** verilog/ssp_pkg.sv ***
// constants and types for the scsi sideband pin control block
package ssp_pkg;

   // ==========================================================
   // clock and timing
   localparam int unsigned PCLK_PERIOD_NS = 40;
   localparam int unsigned ID_CLK_PERIOD_NS = 50;
   // least period rounds up to whole cycles
   localparam int unsigned ID_CLK_CYCLES =
      (ID_CLK_PERIOD_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
   localparam int unsigned ID_CLK_HALF_RAW = ID_CLK_CYCLES / 2;
   localparam int unsigned ID_CLK_HALF =
      (ID_CLK_HALF_RAW < 1) ? 1 : ID_CLK_HALF_RAW;
   localparam logic [3:0] ID_HALF_LAST = 4'(ID_CLK_HALF - 1);

   // ==========================================================
   // serial id load
   localparam int unsigned ID_BITS = 32;
   localparam logic [5:0] ID_LAST_CLK = 6'(ID_BITS - 1);
   // fourth shift clock, counted from zero
   localparam logic [5:0] RAM_SAMPLE_CLK = 6'h03;
   // arbitrary neutral default identifiers
   localparam logic [15:0] DEFAULT_SUBSYS_ID = 16'h0001;
   localparam logic [15:0] DEFAULT_SUBVEND_ID = 16'h0001;

   // ==========================================================
   // register offsets
   localparam logic [7:0] OFF_BLOCK_CTL = 8'h00;
   localparam logic [7:0] OFF_DEV_CFG = 8'h04;
   localparam logic [7:0] OFF_XFER_CTL1 = 8'h08;
   localparam logic [7:0] OFF_CHIP_CTL = 8'h0C;
   localparam logic [7:0] OFF_SERIAL_ID = 8'h10;

   // ==========================================================
   // field positions
   localparam int unsigned BC_LED_DRIVE = 0;
   localparam int unsigned BC_WIDE_PRESENT = 1;
   localparam int unsigned BC_EXPANDER = 2;
   localparam int unsigned BC_HVD_PRESENT = 3;
   localparam int unsigned BC_ACTIVITY = 4;
   localparam int unsigned BC_RUN_IND = 5;
   localparam int unsigned DC_TERM_POL = 0;
   localparam int unsigned DC_MPORT_MODE = 1;
   localparam int unsigned DC_ID_BUSY = 2;
   localparam int unsigned XC_TERM_EN = 0;
   localparam int unsigned CC_SOFT_RST = 0;

   // ==========================================================
   // reset values
   localparam logic RST_LED_DRIVE = 1'b0;
   localparam logic RST_TERM_POL = 1'b0;
   localparam logic RST_TERM_EN = 1'b0;
   localparam logic RST_MPORT_MODE = 1'b0;
   // sideband sync order: ram, wide, hvd, expander (pulled-up ones high)
   localparam logic [3:0] RST_SB_SYNC = 4'hE;
   localparam int unsigned SB_EXPANDER = 0;
   localparam int unsigned SB_HVD = 1;
   localparam int unsigned SB_WIDE = 2;
   localparam int unsigned SB_RAM = 3;

   typedef enum {
      SSP_ID_LOAD,
      SSP_RUN
   } ssp_state_t;

endpackage : ssp_pkg

// *** verilog/ssp_sideband.sv ***
// scsi sideband pin control: status inputs, activity indicator, term power
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/100ps
module ssp_sideband
   import ssp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic expander_active_in,
   input wire logic hvd_transceiver_present_n,
   input wire logic wide_cable_present_n,
   input wire logic ram_present_n,
   input wire logic serial_id_data_in,
   input wire logic selection_in_progress,
   input wire logic selected_as_target,
   input wire logic selected_as_initiator,
   input wire logic scsi_bus_free,
   output logic activity_indicator_n,
   output logic activity_indicator_oe_n,
   output logic term_power_ctl_out,
   output logic term_power_ctl_oe_n,
   output logic sideband_pullup_en,
   output logic id_load_busy,
   output logic memory_port_mode,
   output logic [15:0] subsystem_id,
   output logic [15:0] subvendor_id
);

   // ==========================================================
   // input synchronizers
   logic [3:0] sb_raw;
   logic [3:0] sb_meta_q;
   logic [3:0] sb_sync_q;

   assign sb_raw = {ram_present_n, wide_cable_present_n,
                    hvd_transceiver_present_n, expander_active_in};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sb_meta_q[gi] <= RST_SB_SYNC[gi];
               sb_sync_q[gi] <= RST_SB_SYNC[gi];
            end else begin
               sb_meta_q[gi] <= sb_raw[gi];
               sb_sync_q[gi] <= sb_meta_q[gi];
            end
         end
      end
   endgenerate

   // pad pull-ups on the hvd, wide and ram inputs stay on out of reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sideband_pullup_en <= 1'b0;
      end else begin
         sideband_pullup_en <= 1'b1;
      end
   end

   // ==========================================================
   // apb decode
   logic setup_ph;
   logic access_ph;
   logic addr_hit;
   logic wr_ok;
   logic led_drive_q;
   logic run_ind_q;
   logic activity_q;
   logic term_pol_q;
   logic term_en_q;
   logic soft_rst;
   ssp_state_t state_q;

   assign setup_ph = psel && !penable;
   assign access_ph = psel && penable;
   assign addr_hit = (paddr == OFF_BLOCK_CTL) || (paddr == OFF_DEV_CFG) ||
                     (paddr == OFF_XFER_CTL1) || (paddr == OFF_CHIP_CTL) ||
                     (paddr == OFF_SERIAL_ID);
   assign id_load_busy = (state_q == SSP_ID_LOAD);
   // zero wait states; an error answer is the retry while loading
   assign pready = access_ph;
   assign pslverr = access_ph && (id_load_busy || !addr_hit);
   assign wr_ok = access_ph && pwrite && addr_hit && !id_load_busy;
   assign soft_rst = wr_ok && (paddr == OFF_CHIP_CTL) &&
                     pwdata[CC_SOFT_RST];

   // ==========================================================
   // serial id shift-in after host-bus reset
   logic shift_clk_q;
   logic [3:0] half_cnt_q;
   logic [5:0] clk_idx_q;
   logic rise;
   logic [31:0] serial_id_q;
   logic mport_q;

   // the next toggle takes the shift clock from low to high
   assign rise = id_load_busy && !shift_clk_q && (half_cnt_q == ID_HALF_LAST);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SSP_ID_LOAD;
         shift_clk_q <= 1'b1;
         half_cnt_q <= 4'h0;
         clk_idx_q <= 6'h00;
      end else begin
         unique case (state_q)
            SSP_ID_LOAD: begin
               if (half_cnt_q == ID_HALF_LAST) begin
                  half_cnt_q <= 4'h0;
                  shift_clk_q <= !shift_clk_q;
                  if (rise) begin
                     clk_idx_q <= clk_idx_q + 6'h01;
                     if (clk_idx_q == ID_LAST_CLK) begin
                        state_q <= SSP_RUN;
                     end
                  end
               end else begin
                  half_cnt_q <= half_cnt_q + 4'h1;
               end
            end
            SSP_RUN: begin
               shift_clk_q <= 1'b1;
            end
         endcase
      end
   end

   // bits arrive msb first, subsystem half then subvendor half
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_id_q <= {DEFAULT_SUBSYS_ID, DEFAULT_SUBVEND_ID};
      end else if (rise) begin
         serial_id_q <= {serial_id_q[30:0], serial_id_data_in};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mport_q <= RST_MPORT_MODE;
      end else if (rise && (clk_idx_q == RAM_SAMPLE_CLK)) begin
         mport_q <= sb_sync_q[SB_RAM];
      end
   end

   assign subsystem_id = serial_id_q[31:16];
   assign subvendor_id = serial_id_q[15:0];
   assign memory_port_mode = mport_q;

   // ==========================================================
   // activity indicator sources
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         activity_q <= 1'b0;
      end else if (selection_in_progress || selected_as_target ||
                   selected_as_initiator) begin
         // a new selection wins over a bus free in the same cycle
         activity_q <= 1'b1;
      end else if (scsi_bus_free || soft_rst) begin
         activity_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_ind_q <= 1'b0;
      end else if (rise && (clk_idx_q == ID_LAST_CLK)) begin
         run_ind_q <= 1'b1;
      end else if (wr_ok && (paddr == OFF_BLOCK_CTL) &&
                   pwdata[BC_RUN_IND]) begin
         run_ind_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         led_drive_q <= RST_LED_DRIVE;
      end else if (wr_ok && (paddr == OFF_BLOCK_CTL)) begin
         led_drive_q <= pwdata[BC_LED_DRIVE];
      end
   end

   // registered pin; floats only during host-bus reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         activity_indicator_n <= 1'b1;
         activity_indicator_oe_n <= 1'b1;
      end else begin
         activity_indicator_oe_n <= 1'b0;
         if (id_load_busy) begin
            activity_indicator_n <= shift_clk_q;
         end else begin
            activity_indicator_n <= !(led_drive_q || activity_q ||
                                      run_ind_q);
         end
      end
   end

   // ==========================================================
   // termination power control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         term_pol_q <= RST_TERM_POL;
      end else if (wr_ok && (paddr == OFF_DEV_CFG)) begin
         term_pol_q <= pwdata[DC_TERM_POL];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         term_en_q <= RST_TERM_EN;
      end else if (soft_rst) begin
         term_en_q <= 1'b0;
      end else if (wr_ok && (paddr == OFF_XFER_CTL1)) begin
         term_en_q <= pwdata[XC_TERM_EN];
      end
   end

   // enabled drives the polarity level, disabled its complement
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         term_power_ctl_out <= 1'b0;
         term_power_ctl_oe_n <= 1'b1;
      end else begin
         term_power_ctl_oe_n <= 1'b0;
         if (soft_rst) begin
            term_power_ctl_out <= !term_pol_q;
         end else begin
            term_power_ctl_out <= !(term_pol_q ^ term_en_q);
         end
      end
   end

   // ==========================================================
   // read data, captured in the setup cycle so it leaves a flip-flop
   logic [31:0] rd_d;

   always_comb begin
      rd_d = 32'h0000_0000;
      unique case (paddr)
         OFF_BLOCK_CTL: begin
            rd_d[BC_LED_DRIVE] = led_drive_q;
            rd_d[BC_WIDE_PRESENT] = !sb_sync_q[SB_WIDE];
            rd_d[BC_EXPANDER] = sb_sync_q[SB_EXPANDER];
            rd_d[BC_HVD_PRESENT] = !sb_sync_q[SB_HVD];
            rd_d[BC_ACTIVITY] = activity_q;
            rd_d[BC_RUN_IND] = run_ind_q;
         end
         OFF_DEV_CFG: begin
            rd_d[DC_TERM_POL] = term_pol_q;
            rd_d[DC_MPORT_MODE] = mport_q;
            rd_d[DC_ID_BUSY] = id_load_busy;
         end
         OFF_XFER_CTL1: begin
            rd_d[XC_TERM_EN] = term_en_q;
         end
         OFF_SERIAL_ID: begin
            rd_d = serial_id_q;
         end
         default: begin
            rd_d = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_ph) begin
         prdata <= (id_load_busy || pwrite) ? 32'h0000_0000 : rd_d;
      end
   end

endmodule : ssp_sideband

// *** verif/ssp_sideband_checker.sv ***
// assertion checker for the scsi sideband pin block
`timescale 1ns/100ps
module ssp_sideband_checker
   import ssp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic expander_active_in,
   input wire logic hvd_transceiver_present_n,
   input wire logic wide_cable_present_n,
   input wire logic selection_in_progress,
   input wire logic selected_as_target,
   input wire logic selected_as_initiator,
   input wire logic activity_indicator_n,
   input wire logic activity_indicator_oe_n,
   input wire logic term_power_ctl_oe_n,
   input wire logic id_load_busy,
   input wire logic memory_port_mode
);
   // ==========
   // sequences
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_busy_access;
      psel && penable && id_load_busy;
   endsequence
   sequence s_read_ctl;
      // prdata was loaded in the setup cycle, so busy is judged there
      psel && penable && !pwrite && paddr == OFF_BLOCK_CTL &&
      !$past(id_load_busy);
   endsequence
   sequence s_sel_any;
      (selection_in_progress || selected_as_target ||
       selected_as_initiator) && !id_load_busy;
   endsequence
   // ==========
   // assertions
   a_retry_busy: assert property (
      s_busy_access |-> pready && pslverr && prdata == 32'h0)
      else $error("access during id load not refused");
   // checked in reset too, so the default disable is overridden
   a_float_reset: assert property (
      disable iff (1'h0) !presetn |->
      activity_indicator_oe_n && term_power_ctl_oe_n)
      else $error("pin driven during host reset");
   a_drive_release: assert property (
      $rose(presetn) |-> ##1 !activity_indicator_oe_n && !term_power_ctl_oe_n)
      else $error("pins not driven after reset release");
   a_shift_toggle: assert property (
      // pin is registered from the shift clock, so its first toggle lags
      id_load_busy && $past(id_load_busy) && $past(presetn, 2) |->
      activity_indicator_n != $past(activity_indicator_n))
      else $error("shift clock did not toggle");
   a_run_low: assert property (
      $fell(id_load_busy) |-> ##1 !activity_indicator_n)
      else $error("indicator not active after id load");
   a_mport_hold: assert property (
      !id_load_busy |-> $stable(memory_port_mode))
      else $error("memory port mode changed outside id load");
   a_sync_report: assert property (
      s_read_ctl |-> prdata[3:1] == {~$past(hvd_transceiver_present_n, 3),
      $past(expander_active_in, 3), ~$past(wide_cable_present_n, 3)})
      else $error("sideband status read wrong");
   a_activity_set: assert property (
      s_sel_any |-> ##2 !activity_indicator_n)
      else $error("indicator not latched on selection");
endmodule : ssp_sideband_checker

bind ssp_sideband ssp_sideband_checker i_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
   .expander_active_in, .hvd_transceiver_present_n, .wide_cable_present_n,
   .selection_in_progress, .selected_as_target, .selected_as_initiator,
   .activity_indicator_n, .activity_indicator_oe_n, .term_power_ctl_oe_n,
   .id_load_busy, .memory_port_mode);

// *** verif/ssp_board_model.sv ***
// board model: serial id source and ram-present strap
`timescale 1ns/100ps
module ssp_board_model #(
   parameter logic [31:0] ID_WORD = 32'hC35A_96E1,
   parameter logic RAM_N = 1'h1
) (
   input wire logic presetn,
   input wire logic activity_indicator_n,
   output logic serial_id_data_in,
   output logic ram_present_n
);
   // ==========
   // serial id source, msb first
   int unsigned idx;
   // advance after the rising shift edge, when the device has sampled
   always @(posedge activity_indicator_n or negedge presetn) begin
      if (!presetn) begin
         idx <= 0;
      end else if (idx < 32) begin
         idx <= idx + 1;
      end
   end
   // once done the line no longer holds the last bit
   assign serial_id_data_in =
      (idx < 32) ? ID_WORD[31 - idx] : ~ID_WORD[0];
   assign ram_present_n = RAM_N;
endmodule : ssp_board_model

// *** verif/test_ssp_sideband.sv ***
// self-checking bench for the scsi sideband pin block
`timescale 1ns/100ps
module test_ssp_sideband
   import ssp_pkg::*;
;
   // ==========
   // signals
   localparam logic [31:0] ID_WORD = 32'hC35A_96E1;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic expander_active_in, hvd_transceiver_present_n;
   logic wide_cable_present_n, ram_present_n, serial_id_data_in;
   logic selection_in_progress, selected_as_target, selected_as_initiator;
   logic scsi_bus_free, activity_indicator_n, activity_indicator_oe_n;
   logic term_power_ctl_out, term_power_ctl_oe_n, sideband_pullup_en;
   logic id_load_busy, memory_port_mode;
   logic [15:0] subsystem_id, subvendor_id;
   int n_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   ssp_board_model #(.ID_WORD(ID_WORD)) i_board (.presetn,
      .activity_indicator_n, .serial_id_data_in, .ram_present_n);
   ssp_sideband i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .expander_active_in,
      .hvd_transceiver_present_n, .wide_cable_present_n, .ram_present_n,
      .serial_id_data_in, .selection_in_progress, .selected_as_target,
      .selected_as_initiator, .scsi_bus_free, .activity_indicator_n,
      .activity_indicator_oe_n, .term_power_ctl_out, .term_power_ctl_oe_n,
      .sideband_pullup_en, .id_load_busy, .memory_port_mode, .subsystem_id,
      .subvendor_id);
   initial begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end
   // ==========
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // idle edge keeps two requests from sharing one time step
      @(posedge pclk);
   endtask : apb
   task automatic host_reset();
      presetn <= 1'h0;
      repeat (3) @(posedge pclk);
      chk(activity_indicator_oe_n, 1'h1);
      chk(term_power_ctl_oe_n, 1'h1);
      presetn <= 1'h1;
      @(posedge pclk);
   endtask : host_reset
   task automatic t_load();
      apb(1'h1, OFF_XFER_CTL1, 32'h1);
      chk(err, 1'h1);
      apb(1'h0, OFF_SERIAL_ID, 32'h0);
      chk(rd, 32'h0);
      while (id_load_busy !== 1'h0) @(posedge pclk);
      repeat (2) @(posedge pclk);
      chk(activity_indicator_n, 1'h0);
      chk({subsystem_id, subvendor_id}, ID_WORD);
      chk(memory_port_mode, 1'h1);
      chk(sideband_pullup_en, 1'h1);
      apb(1'h0, OFF_SERIAL_ID, 32'h0);
      chk(rd, ID_WORD);
      apb(1'h0, OFF_DEV_CFG, 32'h0);
      chk(rd, 32'h2);
      apb(1'h0, OFF_XFER_CTL1, 32'h0);
      chk(rd, 32'h0);
      apb(1'h0, OFF_BLOCK_CTL, 32'h0);
      chk(rd, 32'h20);
      apb(1'h1, OFF_BLOCK_CTL, 32'h20);
      @(posedge pclk);
      chk(activity_indicator_n, 1'h1);
   endtask : t_load
   task automatic t_pins();
      for (int i = 0; i < 8; i++) begin
         {expander_active_in, hvd_transceiver_present_n,
          wide_cable_present_n} <= i[2:0];
         repeat (3) @(posedge pclk);
         apb(1'h0, OFF_BLOCK_CTL, 32'h0);
         chk(rd[3:1], {~i[1], i[2], ~i[0]});
      end
      {expander_active_in, hvd_transceiver_present_n,
       wide_cable_present_n} <= 3'h3;
   endtask : t_pins
   task automatic t_activity();
      for (int i = 0; i < 3; i++) begin
         {selection_in_progress, selected_as_target,
          selected_as_initiator} <= 3'h1 << i;
         @(posedge pclk);
         {selection_in_progress, selected_as_target,
          selected_as_initiator} <= 3'h0;
         repeat (3) @(posedge pclk);
         chk(activity_indicator_n, 1'h0);
         scsi_bus_free <= 1'h1;
         @(posedge pclk);
         scsi_bus_free <= 1'h0;
         repeat (2) @(posedge pclk);
         chk(activity_indicator_n, 1'h1);
      end
   endtask : t_activity
   task automatic t_led();
      apb(1'h1, OFF_BLOCK_CTL, 32'h1);
      @(posedge pclk);
      chk(activity_indicator_n, 1'h0);
      apb(1'h1, OFF_BLOCK_CTL, 32'h0);
      @(posedge pclk);
      chk(activity_indicator_n, 1'h1);
      apb(1'h0, 8'h14, 32'h0);
      chk(err, 1'h1);
      chk(rd, 32'h0);
   endtask : t_led
   task automatic t_term();
      for (int i = 0; i < 4; i++) begin
         apb(1'h1, OFF_DEV_CFG, 32'(i[1]));
         apb(1'h1, OFF_XFER_CTL1, 32'(i[0]));
         @(posedge pclk);
         chk(term_power_ctl_out, !(i[1] ^ i[0]));
      end
      apb(1'h1, OFF_CHIP_CTL, 32'h1);
      @(posedge pclk);
      chk(term_power_ctl_out, 1'h0);
      apb(1'h0, OFF_XFER_CTL1, 32'h0);
      chk(rd, 32'h0);
   endtask : t_term
   task automatic final_report();
      if (n_errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report
   // ==========
   // run
   initial begin
      // presetn starts high and is driven low at the first edge so its fall is a real edge
      presetn = 1'h1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {expander_active_in, hvd_transceiver_present_n} = 2'h1;
      {wide_cable_present_n, scsi_bus_free} = 2'h2;
      {selection_in_progress, selected_as_target} = 2'h0;
      selected_as_initiator = 1'h0;
      @(posedge pclk);
      host_reset();
      t_load();
      t_pins();
      t_activity();
      t_led();
      t_term();
      // second load shows polarity cleared by host reset
      host_reset();
      t_load();
      final_report();
   end
   // hang guard, well above the few hundred cycles the run needs
   initial begin
      forever begin
         @(posedge pclk);
         cyc++;
         if (cyc == 3000) begin
            n_errors++;
            final_report();
         end
      end
   end
endmodule : test_ssp_sideband
